// ==== src/ivm_vector_map.sv ====
`timescale 1ns/1ps
`include "ivm_params.svh"
// Overview of operation
// - vector address is the programmable base plus a fixed per-source offset
// - several pending requests: the higher vector offset wins
// - sequence-abort at 0x188, two enables plus mask, wakes wait only
// - conversion-complete at 0x184, ten per-command enables plus mask, wait only
// - supply monitor at 0x140, high and low enables plus mask, wait only
// - port S key-wakeup at 0x124, eight pin enables, wakes stop and wait
// - over-current at 0x108, enable bits 6, 4, 2 to 0, wait only
// - periodic timer at 0x100, own enable plus mask, wakes stop and wait
// - port AD key-wakeup at 0x0F4, sixteen pin enables, wakes stop and wait
// - port L key-wakeup at 0x0C0, two pin enables, wakes stop and wait
// - timer channels 0 to 3 at 0x0AC down to 0x0A0, wait only
module ivm_vector_map (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire ivm_pkg::ivm_flags_type src_flags,
  input  wire logic                  irq_mask,
  output ivm_pkg::ivm_core_type      core_req,
  output logic                       wake_stop,
  output logic                       wake_wait,
  output logic                       evt_irq
);
  import ivm_pkg::*;

  localparam int NSRC = `IVM_NUM_SRC;
  localparam int FW   = `IVM_FLAG_W;

  localparam logic [8:0] OFFS [NSRC] = '{
    `IVM_OFF_SEQ_ABORT, `IVM_OFF_CONV_DONE, `IVM_OFF_BATT,    `IVM_OFF_PORT_S,
    `IVM_OFF_OVERCUR,   `IVM_OFF_PERIODIC,  `IVM_OFF_PORT_AD, `IVM_OFF_PORT_L,
    `IVM_OFF_CHAN0,     `IVM_OFF_CHAN1,     `IVM_OFF_CHAN2,   `IVM_OFF_CHAN3
  };

  initial
  begin
    if (NSRC != 12 || `IVM_VEC_W != 24)
      $error("ivm_vector_map: source table and vector width do not match");
  end

  ivm_state_type         st;
  ivm_state_type         next_st;
  logic [FW-1:0]         src_flag [NSRC];
  logic [FW-1:0]         src_en   [NSRC];
  logic [NSRC-1:0]       src_req;
  logic                  access;
  logic                  addr_ok;
  logic [31:0]           rd_value;

  // flags and enables spread into one lane per source, zero padded
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      src_flag[i] = '0;
      src_en[i]   = '0;
    end
    src_flag[0]  = {14'h0000, src_flags.seq_abort, src_flags.conv_overrun};
    src_en[0]    = {14'h0000, st.seq_abort_irq_en, st.conv_overrun_irq_en};
    src_flag[1]  = {6'h00, src_flags.conv_complete};
    src_en[1]    = {6'h00, st.conv_complete_irq_en};
    src_flag[2]  = {14'h0000, src_flags.batt_high, src_flags.batt_low};
    src_en[2]    = {14'h0000, st.batt_high_irq_en, st.batt_low_irq_en};
    src_flag[3]  = {8'h00, src_flags.port_s};
    src_en[3]    = {8'h00, st.port_s_wake_en};
    src_flag[4]  = {9'h000, src_flags.overcurrent};
    src_en[4]    = {9'h000, st.overcurrent_irq_en & `IVM_OC_EN_MASK};
    src_flag[5]  = {15'h0000, src_flags.periodic};
    src_en[5]    = {15'h0000, st.periodic_timer_irq_en};
    src_flag[6]  = {src_flags.port_ad_high, src_flags.port_ad_low};
    src_en[6]    = {st.port_ad_high_wake_en, st.port_ad_low_wake_en};
    src_flag[7]  = {14'h0000, src_flags.port_l};
    src_en[7]    = {14'h0000, st.port_l_wake_en};
    for (int c = 0; c < 4; c++)
    begin
      src_flag[8+c] = {15'h0000, src_flags.timer_chan[c]};
      src_en[8+c]   = {15'h0000, st.chan_irq_en[c]};
    end
  end

  // one gate per source; the mask blocks every source here
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : gen_gate
      ivm_src_gate #(
        .WIDTH (FW)
      ) u_gate (
        .flags    (src_flag[g]),
        .enables  (src_en[g]),
        .irq_mask (irq_mask),
        .req      (src_req[g])
      );
    end
  endgenerate

  // register decode, only exact aligned addresses answer
  assign access = psel & penable;
  always_comb
  begin
    addr_ok  = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      `IVM_ADDR_BASE:      rd_value = {8'h00, st.vector_base_reg};
      `IVM_ADDR_ADC_EN:    rd_value = {6'h00, st.conv_complete_irq_en, 14'h0000,
                                       st.conv_overrun_irq_en, st.seq_abort_irq_en};
      `IVM_ADDR_SUPPLY_EN: rd_value = {15'h0000, st.periodic_timer_irq_en, 1'b0, st.overcurrent_irq_en,
                                       6'h00, st.batt_low_irq_en, st.batt_high_irq_en};
      `IVM_ADDR_PORT_EN:   rd_value = {6'h00, st.port_l_wake_en, st.port_ad_high_wake_en,
                                       st.port_ad_low_wake_en, st.port_s_wake_en};
      `IVM_ADDR_TIMER_EN:  rd_value = {28'h000_0000, st.chan_irq_en};
      `IVM_ADDR_PENDING:   rd_value = {20'h0_0000, src_req};
      `IVM_ADDR_STATUS:    rd_value = {20'h0_0000, st.evt_status};
      `IVM_ADDR_MASK:      rd_value = {20'h0_0000, st.evt_mask};
      `IVM_ADDR_ACTIVE:    rd_value = {3'b000, st.core.req, st.core.source, st.core.vector};
      default:             addr_ok  = 1'b0;
    endcase
  end

  // whole next state: bus slave, event status, core request and wake
  always_comb
  begin
    logic [11:0] status_clr;
    next_st    = st;
    status_clr = 12'h000;
    case (st.bus_state)
      IVM_IDLE:
      begin
        if (access)
        begin
          // read data latched a cycle ahead so prdata comes from a flop
          next_st.prdata    = rd_value;
          next_st.pslverr   = ~addr_ok;
          next_st.bus_state = IVM_ANSWER;
        end
      end
      IVM_ANSWER:
      begin
        next_st.bus_state = IVM_IDLE;
        next_st.prdata    = 32'h0000_0000;
        next_st.pslverr   = 1'b0;
        if (pwrite && addr_ok)
        begin
          case (paddr)
            `IVM_ADDR_BASE:      next_st.vector_base_reg = {pwdata[23:9], 9'h000};
            `IVM_ADDR_ADC_EN:
            begin
              next_st.seq_abort_irq_en     = pwdata[0];
              next_st.conv_overrun_irq_en  = pwdata[1];
              next_st.conv_complete_irq_en = pwdata[25:16];
            end
            `IVM_ADDR_SUPPLY_EN:
            begin
              next_st.batt_high_irq_en      = pwdata[0];
              next_st.batt_low_irq_en       = pwdata[1];
              next_st.overcurrent_irq_en    = pwdata[14:8] & `IVM_OC_EN_MASK;
              next_st.periodic_timer_irq_en = pwdata[16];
            end
            `IVM_ADDR_PORT_EN:
            begin
              next_st.port_s_wake_en       = pwdata[7:0];
              next_st.port_ad_low_wake_en  = pwdata[15:8];
              next_st.port_ad_high_wake_en = pwdata[23:16];
              next_st.port_l_wake_en       = pwdata[25:24];
            end
            `IVM_ADDR_TIMER_EN:  next_st.chan_irq_en = pwdata[3:0];
            `IVM_ADDR_MASK:      next_st.evt_mask    = pwdata[11:0];
            default:             next_st.evt_mask    = st.evt_mask;
          endcase
        end
        // clear only what the read reported; a bit set since the latch stays pending
        if (!pwrite && paddr == `IVM_ADDR_STATUS)
          status_clr = st.prdata[11:0];
      end
      default:
        next_st.bus_state = IVM_IDLE;
    endcase

    // a request arriving during the clearing read survives it
    next_st.evt_status = (st.evt_status & ~status_clr) | src_req;

    // lowest index has the highest offset, so walk downward and let the last hit win
    next_st.core.req    = |src_req;
    next_st.core.source = 4'h0;
    next_st.core.vector = st.vector_base_reg;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (src_req[i])
      begin
        next_st.core.source = 4'(i);
        next_st.core.vector = st.vector_base_reg + {15'h0000, OFFS[i]};
      end
    end

    // stop only ends for stop-capable sources; any source ends wait
    next_st.wake_stop = |(src_req & `IVM_STOP_CAP);
    next_st.wake_wait = |src_req;
  end

  // state register; enables cleared so nothing is presented after reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st                       <= '0;
      st.bus_state             <= IVM_IDLE;
      st.vector_base_reg       <= `IVM_BASE_RST;
      st.core.vector           <= `IVM_BASE_RST;
      st.evt_mask              <= 12'(`IVM_EN_RST);
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs; pready and the pready-gated pslverr are the combinational handshake terms
  assign pready    = (st.bus_state == IVM_ANSWER);
  assign prdata    = st.prdata;
  assign pslverr   = st.pslverr & pready;
  assign core_req  = st.core;
  assign wake_stop = st.wake_stop;
  assign wake_wait = st.wake_wait;
  assign evt_irq   = |(st.evt_status & st.evt_mask);

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [NSRC-1:0] higher_mask;
  always_comb
  begin
    higher_mask = (12'h001 << st.core.source) - 12'h001;
  end

  a_vector_base_sum: assert property (
    st.core.req |-> st.core.vector == $past(st.vector_base_reg) + {15'h0000, OFFS[st.core.source]})
    else $error("vector is not base plus source offset");

  a_base_aligned: assert property (
    st.vector_base_reg[8:0] == 9'h000)
    else $error("vector base has offset bits set");

  a_priority_order: assert property (
    st.core.req |-> ($past(src_req) & higher_mask) == 12'h000)
    else $error("a higher-offset request was passed over");

  a_seq_abort_path: assert property (
    (src_flags.seq_abort && st.seq_abort_irq_en && !irq_mask) |=>
      st.core.req && st.core.source == 4'h0 && st.core.vector[8:0] == `IVM_OFF_SEQ_ABORT)
    else $error("sequence abort not presented at its offset");

  // a stop-capable source pending alongside would rightly raise wake_stop
  a_conv_done_path: assert property (
    (src_req[1] && !src_req[0] && (src_req & `IVM_STOP_CAP) == 12'h000) |=>
      st.core.vector[8:0] == `IVM_OFF_CONV_DONE && !st.wake_stop)
    else $error("conversion complete vector or wake wrong");

  a_batt_wait_only: assert property (
    (src_req == 12'h004) |=> st.wake_wait && !st.wake_stop && st.core.vector[8:0] == `IVM_OFF_BATT)
    else $error("supply monitor wake or vector wrong");

  a_port_s_stop: assert property (
    src_req[3] |=> st.wake_stop && st.wake_wait)
    else $error("port S did not wake from stop");

  // vectors of sources that stand alone
  a_port_s_vector: assert property (
    (src_req == 12'h008) |=> st.core.vector[8:0] == `IVM_OFF_PORT_S)
    else $error("port S vector wrong");

  a_oc_enable_bits: assert property (
    (st.overcurrent_irq_en & ~`IVM_OC_EN_MASK) == 7'h00)
    else $error("absent over-current enable bit set");

  a_oc_absent_quiet: assert property (
    ((src_flags.overcurrent & `IVM_OC_EN_MASK) == 7'h00) |-> !src_req[4])
    else $error("absent over-current bit raised a request");

  a_oc_vector: assert property (
    (src_req == 12'h010) |=> st.core.vector[8:0] == `IVM_OFF_OVERCUR && !st.wake_stop)
    else $error("over-current vector or wake wrong");

  a_periodic_stop: assert property (
    (src_flags.periodic && st.periodic_timer_irq_en && !irq_mask) |=> st.wake_stop)
    else $error("periodic timer did not wake from stop");

  a_periodic_vector: assert property (
    (src_req == 12'h020) |=> st.core.vector[8:0] == `IVM_OFF_PERIODIC)
    else $error("periodic timer vector wrong");

  a_key_wake_stop: assert property (
    (src_req[6] || src_req[7]) |=> st.wake_stop ##1 $past(st.core.req))
    else $error("key wakeup did not end stop");

  a_port_ad_vector: assert property (
    (src_req == 12'h040) |=> st.core.vector[8:0] == `IVM_OFF_PORT_AD)
    else $error("port AD vector wrong");

  a_port_l_vector: assert property (
    (src_req == 12'h080) |=> st.core.vector[8:0] == `IVM_OFF_PORT_L && st.wake_stop)
    else $error("port L vector or wake wrong");

  a_timer_offsets: assert property (
    (src_req[11:8] != 4'h0 && src_req[7:0] == 8'h00) |=>
      st.core.vector[8:0] >= `IVM_OFF_CHAN3 && st.core.vector[8:0] <= `IVM_OFF_CHAN0 && !st.wake_stop)
    else $error("timer channel vector or wake wrong");

  // gating and wake
  a_masked_quiet: assert property (
    irq_mask |=> !st.core.req && !st.wake_wait)
    else $error("request presented while masked");

  a_disabled_quiet: assert property (
    (st.chan_irq_en == 4'h0 && st.port_l_wake_en == 2'b00) |-> src_req[11:7] == 5'h00)
    else $error("disabled source raised a request");

  a_wait_only_stop: assert property (
    ((src_req & `IVM_STOP_CAP) == 12'h000) |=> !st.wake_stop)
    else $error("wait-only source ended stop");

  a_stop_cap_wake: assert property (
    ((src_req & `IVM_STOP_CAP) != 12'h000) |=> st.wake_stop)
    else $error("stop-capable source did not end stop");

  a_any_wakes_wait: assert property (
    (src_req != 12'h000) |=> st.wake_wait && st.core.req)
    else $error("pending source did not end wait");

  c_mask_blocks: cover property (irq_mask && src_flags != '0);
  c_two_pending: cover property (src_req[0] && src_req[11] ##1 st.core.source == 4'h0);
  c_status_read: cover property (pready && !pwrite && paddr == `IVM_ADDR_STATUS && src_req != 12'h000);
  c_base_moved: cover property (pready && pwrite && paddr == `IVM_ADDR_BASE ##2 st.core.req);
  c_stop_wake: cover property (st.wake_stop);

endmodule : ivm_vector_map

// ==== include/ivm_params.svh ====
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH

// source count and vector width
`define IVM_NUM_SRC        12
`define IVM_VEC_W          24
`define IVM_FLAG_W         16

// vector offsets, highest priority first
`define IVM_OFF_SEQ_ABORT  9'h188
`define IVM_OFF_CONV_DONE  9'h184
`define IVM_OFF_BATT       9'h140
`define IVM_OFF_PORT_S     9'h124
`define IVM_OFF_OVERCUR    9'h108
`define IVM_OFF_PERIODIC   9'h100
`define IVM_OFF_PORT_AD    9'h0F4
`define IVM_OFF_PORT_L     9'h0C0
`define IVM_OFF_CHAN0      9'h0AC
`define IVM_OFF_CHAN1      9'h0A8
`define IVM_OFF_CHAN2      9'h0A4
`define IVM_OFF_CHAN3      9'h0A0

// sources able to end stop mode, bit per source index
`define IVM_STOP_CAP       12'h0E8

// only bits 6, 4, 2, 1 and 0 of the over-current enable exist
`define IVM_OC_EN_MASK     7'h57

// register byte addresses
`define IVM_ADDR_BASE      8'h00
`define IVM_ADDR_ADC_EN    8'h04
`define IVM_ADDR_SUPPLY_EN 8'h08
`define IVM_ADDR_PORT_EN   8'h0C
`define IVM_ADDR_TIMER_EN  8'h10
`define IVM_ADDR_PENDING   8'h14
`define IVM_ADDR_STATUS    8'h18
`define IVM_ADDR_MASK      8'h1C
`define IVM_ADDR_ACTIVE    8'h20

// reset values
`define IVM_BASE_RST       24'hFF_FE00
`define IVM_EN_RST         32'h0000_0000

`endif

// ==== include/ivm_pkg.sv ====
package ivm_pkg;

  typedef enum logic [1:0] {
    IVM_IDLE   = 2'b01,
    IVM_ANSWER = 2'b10
  } ivm_bus_state_type;

  // raw request flags from the peripherals
  typedef struct packed {
    logic       seq_abort;
    logic       conv_overrun;
    logic [9:0] conv_complete;
    logic       batt_high;
    logic       batt_low;
    logic [7:0] port_s;
    logic [6:0] overcurrent;
    logic       periodic;
    logic [7:0] port_ad_low;
    logic [7:0] port_ad_high;
    logic [1:0] port_l;
    logic [3:0] timer_chan;
  } ivm_flags_type;

  // request presented to the core
  typedef struct packed {
    logic        req;
    logic [23:0] vector;
    logic [3:0]  source;
  } ivm_core_type;

  typedef struct packed {
    ivm_bus_state_type bus_state;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [23:0]       vector_base_reg;
    logic              seq_abort_irq_en;
    logic              conv_overrun_irq_en;
    logic [9:0]        conv_complete_irq_en;
    logic              batt_high_irq_en;
    logic              batt_low_irq_en;
    logic [6:0]        overcurrent_irq_en;
    logic              periodic_timer_irq_en;
    logic [7:0]        port_s_wake_en;
    logic [7:0]        port_ad_low_wake_en;
    logic [7:0]        port_ad_high_wake_en;
    logic [1:0]        port_l_wake_en;
    logic [3:0]        chan_irq_en;
    logic [11:0]       evt_status;
    logic [11:0]       evt_mask;
    ivm_core_type      core;
    logic              wake_stop;
    logic              wake_wait;
  } ivm_state_type;

endpackage : ivm_pkg

// ==== src/ivm_src_gate.sv ====
`timescale 1ns/1ps
// one source: any enabled flag raises it, the core mask blocks it
module ivm_src_gate #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] flags,
  input  wire logic [WIDTH-1:0] enables,
  input  wire logic             irq_mask,
  output logic                  req
);

  initial
  begin
    if (WIDTH < 1)
      $error("ivm_src_gate: WIDTH must be at least 1");
  end

  // local enables first, then the maskable-interrupt mask
  assign req = (|(flags & enables)) & ~irq_mask;

endmodule : ivm_src_gate

// ==== verif/ivm_core_model.sv ====
`timescale 1ns/1ps
// core side: holds the maskable-interrupt mask and latches the vector it fetches
module ivm_core_model (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire ivm_pkg::ivm_core_type core_req,
  input  wire logic                  mask_cmd,
  output logic                       irq_mask,
  output logic      [23:0]           fetch_vec
);
  import ivm_pkg::*;
  // mask lags the command by one edge, like a core updating its flags
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_mask  <= 1'b0;
      fetch_vec <= 24'h00_0000;
    end
    else
    begin
      irq_mask <= mask_cmd;
      if (core_req.req)
      begin
        fetch_vec <= core_req.vector; // vector taken while the request stands
      end
    end
  end
endmodule : ivm_core_model

// ==== verif/interrupt_vector_map_tb.sv ====
`timescale 1ns/1ps
module interrupt_vector_map_tb;
  import ivm_pkg::*;
  logic                   clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic                   mask_cmd, irq_mask, wake_stop, wake_wait, evt_irq;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata;
  logic [23:0]            fetch_vec;
  ivm_flags_type          src_flags;
  ivm_core_type           core_req;
  int                     bad_count, checks;
  // offsets from the highest priority down, and the stop-capable sources
  logic [8:0]             offs [12] = '{9'h188, 9'h184, 9'h140, 9'h124, 9'h108, 9'h100,
                                        9'h0F4, 9'h0C0, 9'h0AC, 9'h0A8, 9'h0A4, 9'h0A0};
  localparam logic [11:0] stop_cap = 12'h0E8;
  localparam logic [23:0] base     = 24'h12_3400;

  ivm_vector_map ivm_vector_map_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_flags, .irq_mask, .core_req, .wake_stop, .wake_wait, .evt_irq);
  ivm_core_model ivm_core_model_i (.clk_sys, .sys_rst, .core_req, .mask_cmd, .irq_mask, .fetch_vec);

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // one apb transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    if (n >= 20)
      check(32'h0000_0000, 32'h0000_0001);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
    check({31'h0, e}, 32'h0000_0000);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    check(d, exp);
    check({31'h0, e}, {31'h0, exp_err});
  endtask : rd_chk

  // let two edges pass so registered outputs have landed
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // every field of each selected source raised
  function automatic ivm_flags_type mk(input logic [11:0] s);
    return {s[0], s[0], {10{s[1]}}, s[2], s[2], {8{s[3]}}, {7{s[4]}}, s[5], {8{s[6]}}, {8{s[6]}},
            {2{s[7]}}, s[11:8]};
  endfunction : mk

  task automatic put(input ivm_flags_type f);
    @(posedge clk_sys);
    src_flags <= f;
    settle;
  endtask : put

  // vector and source only mean something while a request stands
  task automatic core_chk(input logic r, input logic [3:0] s, input logic [8:0] o, input logic ws, input logic ww);
    check({31'h0, core_req.req}, {31'h0, r});
    check({30'h0, wake_stop, wake_wait}, {30'h0, ws, ww});
    if (r)
      check({4'h0, core_req.source, core_req.vector}, {4'h0, s, base + {15'h0, o}});
  endtask : core_chk

  task automatic en_all;
    wr(8'h04, 32'h03FF_0003);
    wr(8'h08, 32'h0001_7F03);
    wr(8'h0C, 32'h03FF_FFFF);
    wr(8'h10, 32'h0000_000F);
  endtask : en_all

  task automatic t_reset;
    rd_chk(8'h00, 32'h00FF_FE00, 1'b0);
    rd_chk(8'h0C, 32'h0000_0000, 1'b0);
    core_chk(1'b0, 4'h0, 9'h000, 1'b0, 1'b0);
    check({31'h0, evt_irq}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_regs;
    wr(8'h08, 32'h0001_7F03);
    rd_chk(8'h08, 32'h0001_5703, 1'b0);
    wr(8'h00, 32'h0012_35FF);
    rd_chk(8'h00, {8'h00, base}, 1'b0);
    rd_chk(8'h24, 32'h0000_0000, 1'b1);
    rd_chk(8'h02, 32'h0000_0000, 1'b1);
  endtask : t_regs

  // each source alone: its offset, and whether it may end stop
  task automatic t_single;
    en_all;
    for (int i = 0; i < 12; i++)
    begin
      put(mk(12'h001 << i));
      core_chk(1'b1, i[3:0], offs[i], stop_cap[i], 1'b1);
    end
  endtask : t_single

  // sources drop away from the top: the next highest offset must win
  task automatic t_prio;
    for (int i = 0; i < 12; i++)
    begin
      put(mk(12'hFFF << i));
      core_chk(1'b1, i[3:0], offs[i], |(stop_cap & (12'hFFF << i)), 1'b1);
      check({8'h00, fetch_vec}, {8'h00, base + {15'h0, offs[i]}});
    end
    put(mk(12'hFFF));
    rd_chk(8'h14, 32'h0000_0FFF, 1'b0);
    // active word: request, winner 0, base plus its offset
    rd_chk(8'h20, 32'h1012_3588, 1'b0);
  endtask : t_prio

  task automatic t_irq;
    put(mk(12'h000));
    rd_chk(8'h18, 32'h0000_0FFF, 1'b0);
    wr(8'h1C, 32'h0000_0020);
    rd_chk(8'h1C, 32'h0000_0020, 1'b0);
    put(mk(12'h080));
    put(mk(12'h000));
    check({31'h0, evt_irq}, 32'h0000_0000);
    put(mk(12'h020));
    put(mk(12'h000));
    check({31'h0, evt_irq}, 32'h0000_0001);
    rd_chk(8'h18, 32'h0000_00A0, 1'b0);
    settle;
    check({31'h0, evt_irq}, 32'h0000_0000);
    rd_chk(8'h18, 32'h0000_0000, 1'b0);
  endtask : t_irq

  // local enables, nonexistent enable bits and the core mask all block
  task automatic t_gate;
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h00FF_0000);
    wr(8'h10, 32'h0000_0000);
    put(mk(12'hFFF));
    core_chk(1'b1, 4'h6, 9'h0F4, 1'b1, 1'b1);
    wr(8'h0C, 32'h0000_0000);
    settle;
    core_chk(1'b0, 4'h0, 9'h000, 1'b0, 1'b0);
    en_all;
    put(ivm_flags_type'(52'h1 << 26));
    core_chk(1'b0, 4'h0, 9'h000, 1'b0, 1'b0);
    put(mk(12'hFFF));
    core_chk(1'b1, 4'h0, 9'h188, 1'b1, 1'b1);
    @(posedge clk_sys);
    mask_cmd <= 1'b1;
    settle;
    settle;
    core_chk(1'b0, 4'h0, 9'h000, 1'b0, 1'b0);
    @(posedge clk_sys);
    mask_cmd <= 1'b0;
    put(mk(12'h000));
  endtask : t_gate

  // watchdog sized well above the expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    wrap_up;
  end

  initial
  begin
    sys_rst   = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    src_flags = '0;
    mask_cmd  = 1'b0;
    bad_count = 0;
    checks    = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_regs;
    t_single;
    t_prio;
    t_irq;
    t_gate;
    // second reset in mid-run must restore the base
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    wrap_up;
  end
endmodule : interrupt_vector_map_tb
